/* File: hw/rfb_frame_buffer.sv */
// Frame buffer with host and baseband ports, power and edge timing registers.
// Assumes a decoded host port on clk and a trigger pin from outside clk.
`timescale 1ns/1ps
`default_nettype none

module rfb_frame_buffer #(
    parameter int DEPTH = rfb_pkg::FB_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 host_req,
    input  wire rfb_pkg::rfb_hreq_t   host_cmd,
    output logic                      host_ack,
    output logic [7:0]                host_rdata,
    output logic                      host_denied,
    output logic                      buffer_underrun_flag,
    input  wire rfb_pkg::rfb_trx_t    state_control_reg,
    input  wire logic                 clock_output_pin_run,
    input  wire logic                 state_command_write,
    input  wire logic                 auto_retry_wait,
    input  wire logic                 retry_power_reduce_enable,
    input  wire logic [3:0]           reduced_power_control_level,
    input  wire logic                 ack_frame_sent,
    input  wire logic                 timing_measure_enable,
    input  wire logic                 phase_measure_unit_en,
    input  wire logic [7:0]           phase_measure_value,
    input  wire logic                 tx_trigger_pin,
    input  wire logic                 rx_start,
    input  wire logic                 rx_byte_valid,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_end,
    input  wire rfb_pkg::rfb_meta_t   rx_meta,
    input  wire logic                 tx_byte_req,
    output logic                      pa_buffer_enable,
    output logic                      pa_enable,
    output logic                      modulation_active,
    output logic                      tx_byte_valid,
    output logic [7:0]                tx_byte,
    output logic                      tx_frame_done,
    output logic [3:0]                tx_power_level
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [rfb_pkg::TCNT_W-1:0] PA_LAST  =
        rfb_pkg::TCNT_W'(rfb_pkg::PA_LEAD_CYC - 1);
    localparam logic [rfb_pkg::TCNT_W-1:0] MOD_LAST =
        rfb_pkg::TCNT_W'(rfb_pkg::MOD_DLY_CYC - 1);
    localparam logic [rfb_pkg::CCNT_W-1:0] CCNT_LAST =
        rfb_pkg::CCNT_W'(rfb_pkg::CLOCK_OUTPUT_PIN_CYC - 1);

    if (DEPTH < 128 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be 128 or 256");
    end

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_RAMP,
        TX_SEND
    } rfb_txs_t;

    typedef struct packed {
        logic [DEPTH-1:0][7:0]       mem;
        logic                        valid;
        logic [7:0]                  hptr;
        logic                        hrd_act;
        logic [7:0]                  rptr;
        logic [7:0]                  tptr;
        rfb_txs_t                    txs;
        logic [rfb_pkg::TCNT_W-1:0]  tcnt;
        logic [rfb_pkg::CCNT_W-1:0]  ccnt;
        logic [3:0]                  phase;
        logic [3:0]                  pwr_prog;
        logic [3:0]                  pwr_used;
        logic                        sent;
        logic                        auto_crc;
        rfb_pkg::rfb_meta_t          meta;
        logic [1:0]                  trg;
        logic                        trg_d;
        logic                        ack;
        logic                        denied;
        logic                        ur;
        logic [7:0]                  rdata;
        logic                        pa_buf;
        logic                        pa;
        logic                        mod;
        logic                        tvld;
        logic [7:0]                  tbyte;
        logic                        tdone;
        logic [3:0]                  pwr_out;
    } rfb_st_t;

    rfb_st_t s_r;
    rfb_st_t s_nxt;

    // Clamps the length byte so that a zero length still sends one byte.
    function automatic logic [7:0] frame_len(input logic [7:0] phr);
        logic [7:0] l;
        l = phr & rfb_pkg::LEN_MASK;
        return (l < rfb_pkg::MIN_FRAME) ? rfb_pkg::MIN_FRAME : l;
    endfunction

    // Scales the position inside one output clock period to sixteenths.
    function automatic logic [3:0] clk_phase(input logic [rfb_pkg::CCNT_W-1:0] c);
        return 4'((32'(c) * rfb_pkg::PHASE_STEPS) / rfb_pkg::CLOCK_OUTPUT_PIN_CYC);
    endfunction

    logic        acc_ok;
    logic        asleep;
    logic        h_go;
    logic        h_fb;
    logic [7:0]  hidx;
    logic        trg_edge;
    logic        tx_take;
    logic        tx_last;
    logic        rx_store;
    logic        eng_hit;
    logic [7:0]  eng_addr;
    logic [7:0]  flen;
    logic [3:0]  shown_pwr;
    logic [7:0]  reg_rd;
    logic [7:0]  fb_rd;
    logic [7:0]  tx_sel;
    logic        fcs_en;
    logic [15:0] fcs;

    assign asleep   = state_control_reg == rfb_pkg::ST_SLEEP || state_control_reg == rfb_pkg::ST_DEEP;
    assign acc_ok   = !asleep
                    && !(state_control_reg == rfb_pkg::ST_P_ON && !clock_output_pin_run);
    assign h_go     = host_req && acc_ok;
    assign h_fb     = h_go && (host_cmd.op == rfb_pkg::HOP_FB_RD
                    || host_cmd.op == rfb_pkg::HOP_FB_WR);
    assign hidx     = host_cmd.first ? 8'h00 : s_r.hptr;
    assign trg_edge = s_r.trg[1] && !s_r.trg_d;
    assign flen     = frame_len(s_r.mem[0]);
    assign tx_take  = s_r.txs == TX_SEND && tx_byte_req;
    assign tx_last  = tx_take && s_r.tptr >= flen;
    assign rx_store = rx_byte_valid && !auto_retry_wait && 32'(s_r.rptr) < DEPTH;
    assign eng_hit  = rx_store || tx_take;
    assign eng_addr = rx_store ? s_r.rptr : s_r.tptr;

    // The checksum covers the PSDU without its two trailing octets.
    assign fcs_en = tx_take && s_r.tptr != 8'h00 && s_r.tptr < flen - 8'h01;

    rfb_fcs16 u_fcs (
        .clk   (clk),
        .rst   (rst),
        .clear (s_r.txs == TX_RAMP),
        .en    (fcs_en),
        .data  (s_r.mem[s_r.tptr[AW-1:0]]),
        .fcs   (fcs)
    );

    always_comb
    begin
        tx_sel = s_r.mem[s_r.tptr[AW-1:0]];
        if (s_r.auto_crc && s_r.tptr != 8'h00 && s_r.tptr == flen - 8'h01)
            tx_sel = fcs[7:0];
        else if (s_r.auto_crc && s_r.tptr != 8'h00 && s_r.tptr == flen)
            tx_sel = fcs[15:8];
    end

    assign shown_pwr = (retry_power_reduce_enable && s_r.sent)
                     ? s_r.pwr_used : s_r.pwr_prog;

    always_comb
    begin
        reg_rd = 8'h00;
        if (host_cmd.addr == rfb_pkg::REG_TX_POWER_LEVEL)
            reg_rd = {s_r.auto_crc, 3'h0, shown_pwr};
        else if (host_cmd.addr == rfb_pkg::REG_TX_TIME && timing_measure_enable)
            reg_rd = phase_measure_unit_en ? phase_measure_value
                   : {4'h0, s_r.phase};
    end

    // Frame-mode reads run past the frame into the stored receive details.
    always_comb
    begin
        fb_rd = 8'h00;
        if (!s_r.valid)
            fb_rd = 8'h00;
        else if (hidx <= flen)
            fb_rd = s_r.mem[hidx[AW-1:0]];
        else if (hidx == flen + 8'h01)
            fb_rd = s_r.meta.lqi;
        else if (hidx == flen + 8'h02)
            fb_rd = s_r.meta.ed;
        else if (hidx == flen + 8'h03)
            fb_rd = s_r.meta.status;
    end

    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.ack   = 1'b0;
        s_nxt.ur    = 1'b0;
        s_nxt.tvld  = 1'b0;
        s_nxt.tdone = 1'b0;
        s_nxt.trg   = {s_r.trg[0], tx_trigger_pin};
        s_nxt.trg_d = s_r.trg[1];
        s_nxt.ccnt  = (s_r.ccnt == CCNT_LAST) ? '0 : s_r.ccnt + 1'b1;
        s_nxt.pwr_out = retry_power_reduce_enable ? reduced_power_control_level
                      : s_r.pwr_prog;

        if (trg_edge)
            s_nxt.phase = clk_phase(s_r.ccnt);

        if (state_command_write)
            s_nxt.sent = 1'b0;
        if (tx_last || ack_frame_sent)
        begin
            s_nxt.pwr_used = s_r.pwr_out;
            s_nxt.sent     = 1'b1;
        end

        if (host_req)
        begin
            s_nxt.ack    = 1'b1;
            s_nxt.denied = !acc_ok;
            s_nxt.rdata  = 8'h00;
        end

        if (h_go)
        begin
            unique case (host_cmd.op)
                rfb_pkg::HOP_REG_RD:
                    s_nxt.rdata = reg_rd;
                rfb_pkg::HOP_REG_WR:
                    if (host_cmd.addr == rfb_pkg::REG_TX_POWER_LEVEL)
                    begin
                        s_nxt.pwr_prog = host_cmd.wdata[3:0];
                        s_nxt.auto_crc = host_cmd.wdata[rfb_pkg::AUTO_CRC_BIT];
                    end
                rfb_pkg::HOP_FB_RD:
                begin
                    s_nxt.rdata   = fb_rd;
                    s_nxt.hptr    = (hidx == 8'hFF) ? hidx : hidx + 8'h01;
                    s_nxt.hrd_act = !host_cmd.last;
                end
                rfb_pkg::HOP_FB_WR:
                begin
                    if (hidx > rfb_pkg::MAX_FRAME)
                        s_nxt.ur = 1'b1;
                    else
                    begin
                        s_nxt.mem[hidx[AW-1:0]] = host_cmd.wdata;
                        s_nxt.valid = 1'b1;
                    end
                    if (s_r.txs != TX_IDLE && hidx <= s_r.tptr)
                        s_nxt.ur = 1'b1;
                    s_nxt.hptr = (hidx == 8'hFF) ? hidx : hidx + 8'h01;
                end
                rfb_pkg::HOP_SR_RD:
                    s_nxt.rdata = s_r.valid ? s_r.mem[host_cmd.addr[AW-1:0]] : 8'h00;
                rfb_pkg::HOP_SR_WR:
                begin
                    s_nxt.mem[host_cmd.addr[AW-1:0]] = host_cmd.wdata;
                    s_nxt.valid = 1'b1;
                end
                default:
                    s_nxt.rdata = 8'h00;
            endcase
        end

        // Both ports finish; a shared address is reported, never stalled.
        if (h_fb && eng_hit && hidx == eng_addr)
            s_nxt.ur = 1'b1;

        if (rx_start && !auto_retry_wait)
        begin
            s_nxt.rptr  = 8'h00;
            s_nxt.valid = 1'b1;
            if (s_r.hrd_act)
                s_nxt.ur = 1'b1;
        end
        if (rx_store)
        begin
            s_nxt.mem[s_r.rptr[AW-1:0]] = rx_byte;
            s_nxt.rptr = s_r.rptr + 8'h01;
        end
        if (rx_end && !auto_retry_wait)
            s_nxt.meta = rx_meta;

        unique case (s_r.txs)
            TX_IDLE:
                if (trg_edge && (state_control_reg == rfb_pkg::ST_PLL_ON
                    || state_control_reg == rfb_pkg::ST_ARET_ON))
                begin
                    s_nxt.txs    = TX_RAMP;
                    s_nxt.tcnt   = '0;
                    s_nxt.pa_buf = 1'b1;
                end
            TX_RAMP:
            begin
                s_nxt.tcnt = s_r.tcnt + 1'b1;
                if (s_r.tcnt == PA_LAST)
                    s_nxt.pa = 1'b1;
                if (s_r.tcnt == MOD_LAST)
                begin
                    s_nxt.txs  = TX_SEND;
                    s_nxt.mod  = 1'b1;
                    s_nxt.tptr = 8'h00;
                end
            end
            TX_SEND:
                if (tx_take)
                begin
                    s_nxt.tvld  = 1'b1;
                    s_nxt.tbyte = tx_sel;
                    s_nxt.tptr  = s_r.tptr + 8'h01;
                    if (tx_last)
                    begin
                        s_nxt.txs    = TX_IDLE;
                        s_nxt.pa_buf = 1'b0;
                        s_nxt.pa     = 1'b0;
                        s_nxt.mod    = 1'b0;
                        s_nxt.tdone  = 1'b1;
                    end
                end
            default:
                s_nxt.txs = TX_IDLE;
        endcase

        // Sleep powers the array down, so its contents stop being readable.
        if (asleep)
        begin
            s_nxt.valid   = 1'b0;
            s_nxt.hrd_act = 1'b0;
        end
    end

    // Reset clears everything; the power field thus starts at its strongest step.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign host_ack             = s_r.ack;
    assign host_rdata           = s_r.rdata;
    assign host_denied          = s_r.denied;
    assign buffer_underrun_flag = s_r.ur;
    assign pa_buffer_enable     = s_r.pa_buf;
    assign pa_enable            = s_r.pa;
    assign modulation_active    = s_r.mod;
    assign tx_byte_valid        = s_r.tvld;
    assign tx_byte              = s_r.tbyte;
    assign tx_frame_done        = s_r.tdone;
    assign tx_power_level       = s_r.pwr_out;

    // Cycles since the PA buffer came on, read only by the checks below.
    logic [15:0] a_cnt;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            a_cnt <= '0;
        else if (!s_r.pa_buf)
            a_cnt <= '0;
        else
            a_cnt <= a_cnt + 16'h0001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_pa_on;
        $rose(s_r.pa);
    endsequence

    sequence s_buf_first;
        s_r.pa_buf && !s_r.mod;
    endsequence

    a_mod_delay: assert property ($rose(s_r.mod) |-> a_cnt == rfb_pkg::MOD_DLY_CYC)
        else $error("modulation did not start 16 us after the PA buffer");
    a_pa_order: assert property (s_pa_on |-> s_buf_first)
        else $error("PA came on before its buffer or after modulation");
    a_cmd_restore: assert property (state_command_write && !tx_last && !ack_frame_sent
        |=> !s_r.sent)
        else $error("state command did not restore the programmed power");
    a_overflow_flag: assert property (h_go && host_cmd.op == rfb_pkg::HOP_FB_WR
        && hidx > rfb_pkg::MAX_FRAME |=> buffer_underrun_flag)
        else $error("frame overflow not flagged");
    a_rx_overrun: assert property (rx_start && !auto_retry_wait && s_r.hrd_act
        |=> buffer_underrun_flag)
        else $error("frame arrival during host read not flagged");
    a_tx_wrptr: assert property (h_go && host_cmd.op == rfb_pkg::HOP_FB_WR
        && s_r.txs != TX_IDLE && hidx <= s_r.tptr |=> buffer_underrun_flag)
        else $error("host write behind send pointer not flagged");
    a_sleep_loss: assert property (asleep |=> !s_r.valid ##1 host_rdata == 8'h00
        || !$past(host_req && host_cmd.op != rfb_pkg::HOP_REG_RD))
        else $error("buffer contents survived sleep");
    a_aret_keep: assert property (auto_retry_wait |=> $stable(s_r.rptr))
        else $error("frame stored while awaiting acknowledgement");

endmodule // rfb_frame_buffer

`default_nettype wire

/* File: hw/rfb_pkg.sv */
// Constants, enumerations and carriers of the radio frame buffer block.
// Assumes a 100 MHz core clock and a host port already decoded from SPI.
// Notes on behaviour
// - One buffer, host port and engine port together.
// - Buffer spans 0x00 to 0x7F, one frame.
// - Port collision raises the underrun flag.
// - Frame write past 127 octets raises underrun.
// - Host access only with core regulator on.
// - Contents kept until write, receive, sleep, reset.
// - Frame arriving during host frame read flags underrun.
// - Awaiting acknowledgement, received frames are not stored.
// - Only sleep states and reset lose contents.
// - Buffer holds length byte and PSDU only.
// - LQI, ED, status follow frame on read.
// - Random read sees length byte at zero.
// - Automatic FCS replaces last two PSDU bytes.
// - Shortest frame is length byte plus one.
// - Trigger edge: PA buffer, PA, modulation 16 us.
// - Four-bit power field, resets to strongest.
// - State command restores programmed power value.
// - Retry power control shows last used power.
// - Timing register shows trigger phase or measurement.
// - Host and engine keep separate pointers.
// - Random access never flags violations.
// - Host write at or below send pointer flags.
package rfb_pkg;

    localparam int         CLK_MHZ      = 100;
    localparam int         FB_DEPTH     = 128;
    localparam logic [7:0] MAX_FRAME    = 8'h7F;
    localparam logic [7:0] MIN_FRAME    = 8'h01;
    localparam logic [7:0] LEN_MASK     = 8'h7F;
    localparam logic [7:0] REG_TX_POWER_LEVEL   = 8'h05;
    localparam logic [7:0] REG_TX_TIME  = 8'h3B;
    localparam logic [3:0] TX_POWER_LEVEL_RST   = 4'h0;
    localparam int         AUTO_CRC_BIT = 7;
    localparam logic [15:0] FCS_POLY    = 16'h8408;
    localparam logic [15:0] FCS_INIT    = 16'h0000;

    localparam int MOD_DLY_NS  = 16000;
    localparam int MOD_DLY_CYC = (MOD_DLY_NS * CLK_MHZ + 999) / 1000;
    localparam int PA_LEAD_NS  = 2000;
    localparam int PA_LEAD_CYC = (PA_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int CLOCK_OUTPUT_PIN_NS     = 1000;
    localparam int CLOCK_OUTPUT_PIN_CYC    = CLOCK_OUTPUT_PIN_NS * CLK_MHZ / 1000;
    localparam int PHASE_STEPS = 16;
    localparam int TCNT_W      = $clog2(MOD_DLY_CYC + 1);
    localparam int CCNT_W      = $clog2(CLOCK_OUTPUT_PIN_CYC);

    typedef enum logic [2:0] {
        HOP_REG_RD,
        HOP_REG_WR,
        HOP_FB_RD,
        HOP_FB_WR,
        HOP_SR_RD,
        HOP_SR_WR
    } rfb_hop_t;

    typedef enum logic [3:0] {
        ST_P_ON,
        ST_SLEEP,
        ST_DEEP,
        ST_TRX_OFF,
        ST_PLL_ON,
        ST_RX_ON,
        ST_BUSY_RX,
        ST_BUSY_TX,
        ST_ARET_ON
    } rfb_trx_t;

    typedef struct packed {
        rfb_hop_t   op;
        logic       first;
        logic       last;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfb_hreq_t;

    typedef struct packed {
        logic [7:0] lqi;
        logic [7:0] ed;
        logic [7:0] status;
    } rfb_meta_t;

endpackage

/* File: hw/rfb_fcs16.sv */
// Running frame check sequence over the bytes that the sender feeds.
// Assumes bytes arrive least significant bit first, one per enable.
`timescale 1ns/1ps
`default_nettype none

module rfb_fcs16 (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] fcs
);

    typedef struct packed {
        logic [15:0] crc;
    } rfb_fcs_st_t;

    rfb_fcs_st_t s_r;
    rfb_fcs_st_t s_nxt;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 0; i < 8; i++)
        begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ rfb_pkg::FCS_POLY) : (x >> 1);
        end
        return x;
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        if (clear)
            s_nxt.crc = rfb_pkg::FCS_INIT;
        else if (en)
            s_nxt.crc = crc_byte(s_r.crc, data);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign fcs = s_r.crc;

endmodule // rfb_fcs16

`default_nettype wire

/* File: tb/rfb_host_model.sv */
// Host side of the frame buffer: issues host port requests and drives the trigger pin.
// Assumes the block answers each request with an acknowledge one cycle later.
`timescale 1ns/1ps
`default_nettype none

module rfb_host_model (
    input  wire logic          clk,
    output logic               host_req,
    output rfb_pkg::rfb_hreq_t host_cmd,
    input  wire logic          host_ack,
    input  wire logic [7:0]    host_rdata,
    input  wire logic          host_denied,
    output logic               tx_trigger_pin
);
    initial
    begin
        host_req       = 1'b0;
        host_cmd       = '0;
        tx_trigger_pin = 1'b0;
    end

    // One request cycle every other cycle keeps the host well ahead of the air rate.
    task automatic acc(input rfb_pkg::rfb_hop_t op, input logic f, l, input logic [7:0] a, d,
                       output logic [8:0] r);
        int n;
        @(posedge clk);
        #1 host_req = 1'b1;
        host_cmd = '{op, f, l, a, d};
        @(posedge clk);
        #1 host_req = 1'b0;
        host_cmd = rfb_pkg::rfb_hreq_t'(~host_cmd);
        for (n = 0; n < 4 && host_ack !== 1'b1; n++) @(posedge clk) #1;
        r = (n < 4) ? {host_denied, host_rdata} : 9'hX;
    endtask

    // The pin edge lands off the clock grid, as from an unrelated host timer.
    task automatic fire();
        #63 tx_trigger_pin = 1'b1;
        #125 tx_trigger_pin = 1'b0;
    endtask
endmodule // rfb_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the frame buffer block.
// Assumes the host model drives the host port and the trigger pin.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, rst, host_req, host_ack, host_denied, buffer_underrun_flag, ur_seen;
    logic clock_output_pin_run, state_command_write, auto_retry_wait, ack_frame_sent;
    logic retry_power_reduce_enable, timing_measure_enable, phase_measure_unit_en;
    logic tx_trigger_pin, rx_start, rx_byte_valid, rx_end, tx_byte_req, tx_frame_done;
    logic pa_buffer_enable, pa_enable, modulation_active, tx_byte_valid;
    logic [3:0]  reduced_power_control_level, tx_power_level;
    logic [7:0]  host_rdata, phase_measure_value, rx_byte, tx_byte;
    logic [8:0]  r;
    logic [15:0] fcs;
    int          mismatches, n_compared, cyc;
    rfb_pkg::rfb_hreq_t host_cmd;
    rfb_pkg::rfb_trx_t  state_control_reg;
    rfb_pkg::rfb_meta_t rx_meta;
    localparam rfb_pkg::rfb_hop_t RR = rfb_pkg::HOP_REG_RD, RW = rfb_pkg::HOP_REG_WR;
    localparam rfb_pkg::rfb_hop_t FR = rfb_pkg::HOP_FB_RD, FW = rfb_pkg::HOP_FB_WR;
    localparam rfb_pkg::rfb_hop_t SR = rfb_pkg::HOP_SR_RD, SW = rfb_pkg::HOP_SR_WR;

    rfb_frame_buffer i_rfb_frame_buffer (.clk, .rst, .host_req, .host_cmd, .host_ack,
        .host_rdata, .host_denied, .buffer_underrun_flag, .state_control_reg, .clock_output_pin_run,
        .state_command_write, .auto_retry_wait, .retry_power_reduce_enable,
        .reduced_power_control_level, .ack_frame_sent, .timing_measure_enable,
        .phase_measure_unit_en, .phase_measure_value, .tx_trigger_pin, .rx_start,
        .rx_byte_valid, .rx_byte, .rx_end, .rx_meta, .tx_byte_req, .pa_buffer_enable,
        .pa_enable, .modulation_active, .tx_byte_valid, .tx_byte, .tx_frame_done,
        .tx_power_level);
    rfb_host_model i_rfb_host_model (.clk, .host_req, .host_cmd, .host_ack, .host_rdata,
        .host_denied, .tx_trigger_pin);

    always #5 clk = ~clk;
    // Underrun pulses are one cycle wide, so they are caught here and judged later.
    always @(posedge clk) if (buffer_underrun_flag === 1'b1) ur_seen <= 1'b1;
    always @(posedge clk) cyc <= (pa_buffer_enable === 1'b1) ? cyc + 1 : 0;

    task automatic check(input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic acc(input rfb_pkg::rfb_hop_t op, input logic f, l, input logic [7:0] a, d);
        i_rfb_host_model.acc(op, f, l, a, d, r);
    endtask

    function automatic logic [15:0] crc16(input logic [15:0] d);
        logic [15:0] c;
        c = rfb_pkg::FCS_INIT;
        for (int i = 0; i < 16; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ rfb_pkg::FCS_POLY) : (c >> 1);
        return c;
    endfunction

    task automatic t_regs();
        acc(RR, 0, 0, rfb_pkg::REG_TX_POWER_LEVEL, 8'h00);
        check(r, 9'h000);
        acc(RW, 0, 0, rfb_pkg::REG_TX_POWER_LEVEL, 8'hFF);
        acc(RR, 0, 0, rfb_pkg::REG_TX_POWER_LEVEL, 8'h00);
        check(r, 9'h08F);
        check(tx_power_level, 4'hF);
        acc(RR, 0, 0, 8'h10, 8'h00);
        check(r, 9'h000);
        acc(RR, 0, 0, rfb_pkg::REG_TX_TIME, 8'h00);
        check(r, 9'h000);
        {timing_measure_enable, phase_measure_unit_en, phase_measure_value} = 10'h3A5;
        acc(RR, 0, 0, rfb_pkg::REG_TX_TIME, 8'h00);
        check(r, 9'h0A5);
    endtask

    task automatic t_power();
        {retry_power_reduce_enable, reduced_power_control_level} = 5'h13;
        step(1);
        ack_frame_sent = 1;
        step(1);
        ack_frame_sent = 0;
        acc(RR, 0, 0, rfb_pkg::REG_TX_POWER_LEVEL, 8'h00);
        check({r, tx_power_level}, 13'h0833);
        state_command_write = 1;
        step(1);
        state_command_write = 0;
        acc(RR, 0, 0, rfb_pkg::REG_TX_POWER_LEVEL, 8'h00);
        check({r, tx_power_level}, 13'h08F3);
    endtask

    task automatic rx_frame(input logic [7:0] b0, b1, b2);
        rx_start = 1;
        step(1);
        {rx_start, rx_byte_valid, rx_byte} = {2'b01, b0};
        step(1);
        rx_byte = b1;
        step(1);
        rx_byte = b2;
        step(1);
        {rx_byte_valid, rx_end} = 2'b01;
        step(1);
        rx_end = 0;
    endtask

    task automatic t_rx();
        logic [7:0] ex[6] = '{8'h02, 8'hAA, 8'hBB, 8'hC1, 8'hC2, 8'hC3};
        rx_meta = '{8'hC1, 8'hC2, 8'hC3};
        rx_frame(8'h02, 8'hAA, 8'hBB);
        state_control_reg = rfb_pkg::ST_PLL_ON;
        step(3200);
        for (int i = 0; i < 6; i++)
        begin
            acc(FR, i == 0, i == 5, 8'h00, 8'h00);
            check(r, {1'b0, ex[i]});
        end
        acc(SR, 0, 0, 8'h00, 8'h00);
        check(r, 9'h002);
        auto_retry_wait = 1;
        rx_frame(8'h07, 8'h01, 8'h02);
        auto_retry_wait = 0;
        acc(SR, 0, 0, 8'h01, 8'h00);
        check(r, 9'h0AA);
        ur_seen = 0;
        acc(FR, 1, 0, 8'h00, 8'h00);
        rx_start = 1;
        step(1);
        rx_start = 0;
        step(2);
        check(ur_seen, 1'b1);
        acc(FR, 0, 1, 8'h00, 8'h00);
    endtask

    task automatic t_sleep();
        rfb_pkg::rfb_trx_t s[2] = '{rfb_pkg::ST_SLEEP, rfb_pkg::ST_DEEP};
        state_control_reg = rfb_pkg::ST_P_ON;
        acc(SR, 0, 0, 8'h01, 8'h00);
        check(r, 9'h100);
        clock_output_pin_run = 1;
        acc(SR, 0, 0, 8'h01, 8'h00);
        check(r, 9'h0AA);
        for (int i = 0; i < 2; i++)
        begin
            state_control_reg = s[i];
            acc(SR, 0, 0, 8'h01, 8'h00);
            check(r, 9'h100);
            state_control_reg = rfb_pkg::ST_TRX_OFF;
            acc(SR, 0, 0, 8'h01, 8'h00);
            check(r, 9'h000);
            acc(SW, 0, 0, 8'h01, 8'hAA);
        end
    endtask

    task automatic t_ovf();
        ur_seen = 0;
        for (int n = 0; n < 128; n++)
            acc(FW, n == 0, 0, 8'h00, n[7:0]);
        acc(SR, 0, 0, 8'h7F, 8'h00);
        check({ur_seen, r}, 10'h07F);
        acc(FW, 0, 0, 8'h00, 8'h00);
        step(1);
        check(ur_seen, 1'b1);
    endtask

    task automatic t_tx();
        logic [7:0] fr[5];
        int n;
        fcs = crc16(16'h2211);
        fr = '{8'h04, 8'h11, 8'h22, fcs[7:0], fcs[15:8]};
        for (n = 0; n < 5; n++)
            acc(FW, n == 0, 0, 8'h00, (n < 3) ? fr[n] : 8'h00);
        state_control_reg = rfb_pkg::ST_PLL_ON;
        i_rfb_host_model.fire();
        for (n = 0; n < 20 && pa_buffer_enable !== 1'b1; n++) step(1);
        check(pa_buffer_enable, 1'b1);
        ur_seen = 0;
        acc(SW, 0, 0, 8'h00, 8'h04);
        step(1);
        check(ur_seen, 1'b0);
        acc(FW, 1, 0, 8'h00, 8'h04);
        step(1);
        check(ur_seen, 1'b1);
        for (n = 0; n < 300 && pa_enable !== 1'b1; n++) step(1);
        check(cyc, 16'd200);
        for (n = 0; n < 1600 && modulation_active !== 1'b1; n++) step(1);
        check(cyc, 16'd1600);
        for (n = 0; n < 5; n++)
        begin
            tx_byte_req = 1;
            step(1);
            tx_byte_req = 0;
            check({tx_byte_valid, tx_frame_done, tx_byte}, {1'b1, n == 4, fr[n]});
            step(1);
        end
    endtask

    initial
    begin
        {clk, rst, clock_output_pin_run, state_command_write, auto_retry_wait,
         ack_frame_sent, retry_power_reduce_enable, timing_measure_enable, phase_measure_unit_en,
         tx_byte_req, rx_start, rx_byte_valid, rx_end, ur_seen} = '0;
        {reduced_power_control_level, phase_measure_value, rx_byte, rx_meta} = '0;
        {mismatches, n_compared, cyc} = '0;
        state_control_reg = rfb_pkg::ST_TRX_OFF;
        rst = 1;
        repeat (5) @(posedge clk);
        #1 rst = 0;
        t_regs();
        t_power();
        t_rx();
        t_sleep();
        t_ovf();
        t_tx();
        give_verdict();
    end

    initial
    begin
        #1000000;
        mismatches++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
